// ### pkg/irqplc_map.svh
// Behaviour
// RULE1: field code 00 disables, 01 level 0, 10 level 1, 11 level 2.
// RULE2: these sources never reach level 3; level 2 is their top.
// RULE3: unused bits 9-8 of reg one, 11-10 of reg two read 0.
// RULE4: every field resets to the disabled code.
// RULE5: reg one bits 15-14, 13-12, 11-10 hold port B, C, D levels.
// RULE6: reg one bits 7-6 flash buffers empty, 5-4 command done.
// RULE7: reg one bits 3-2 flash fault, 1-0 clock lock change.
// RULE8: reg two bits 15-14 serial rx full, 13-12 serial rx fault.
// RULE9: reg two bits 9-8 serial tx idle, 7-6 serial tx empty.
// RULE10: reg two bits 5-4 sync tx, 3-2 sync rx, 1-0 port A.
// RULE11: reg three bits 15-14 converter A done, 13-12 timer three.
// RULE12: within a level the lowest source number wins.
// RULE13: wake only if source was enabled before low power entry.
// RULE14: disabled sources never reach encoders nor pend to the core.
// RULE15: software enables a field only once its source is ready.
`ifndef IRQPLC_MAP_SVH
`define IRQPLC_MAP_SVH
`define IRQPLC_NSRC 16
// word indices; byte address is four times the index
`define IRQPLC_IDX_SEL1 6'h01
`define IRQPLC_IDX_SEL2 6'h02
`define IRQPLC_IDX_SEL3 6'h03
`define IRQPLC_IDX_STAT 6'h04
`define IRQPLC_IDX_CLR 6'h05
`define IRQPLC_IDX_EN 6'h06
`define IRQPLC_IDX_PEND 6'h07
// writable bits and reset values
`define IRQPLC_MASK1 16'hFCFF
`define IRQPLC_MASK2 16'hF3FF
`define IRQPLC_MASK3 16'hF000
`define IRQPLC_RST_SEL 16'h0000
`define IRQPLC_RST_STAT 4'h0
// field low bit positions
`define IRQPLC_POS_PORT_B 14
`define IRQPLC_POS_PORT_C 12
`define IRQPLC_POS_PORT_D 10
`define IRQPLC_POS_FL_BUF 6
`define IRQPLC_POS_FL_DONE 4
`define IRQPLC_POS_FL_FAULT 2
`define IRQPLC_POS_CLK_LOCK 0
`define IRQPLC_POS_SER_RXF 14
`define IRQPLC_POS_SER_RXE 12
`define IRQPLC_POS_SER_TXI 8
`define IRQPLC_POS_SER_TXE 6
`define IRQPLC_POS_SYN_TX 4
`define IRQPLC_POS_SYN_RX 2
`define IRQPLC_POS_PORT_A 0
`define IRQPLC_POS_CONV_A 14
`define IRQPLC_POS_TIMER3 12
`endif

// ### pkg/irqplc_pkg.sv
package irqplc_pkg;
  typedef logic [1:0] irqplc_lvl_t;
  typedef logic [3:0] irqplc_src_t;
  typedef enum logic {BUS_IDLE, BUS_RDWAIT} irqplc_bus_e;
endpackage

// ### rtl/irqplc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "irqplc_map.svh"
module irqplc_top
  import irqplc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] src_req,
  input wire logic [1:0] core_mask,
  input wire logic low_power,
  output logic core_irq,
  output irqplc_lvl_t core_lvl,
  output irqplc_src_t core_src,
  output logic [2:0] lvl_pend,
  output logic wake,
  output logic irq
);

  // lowest set index of a request vector
  function automatic irqplc_src_t first_idx(input logic [15:0] v);
    first_idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        first_idx = 4'(i);
      end
    end
  endfunction

  logic [15:0] sel1_r, sel2_r, sel3_r;
  logic [3:0] stat_r, en_r, stat_nxt;
  logic [5:0] addr_r;
  logic wr_pend_r, lp_d_r, irq_r, wake_r, hreadyout_r, core_irq_r;
  logic [31:0] hrdata_r;
  logic [15:0] arm_r;
  logic [2:0] lvl_pend_r;
  irqplc_lvl_t core_lvl_r;
  irqplc_src_t core_src_r;
  irqplc_bus_e st_r;
  logic [1:0] fld [16];
  logic [15:0] lvl_vec [3];
  logic [15:0] en_vec;
  logic [2:0] lvl_any;
  logic sel_ok;
  irqplc_lvl_t sel_lvl;
  logic acc, wr1, wr2, wr3, wr_clr, wr_en, wake_nxt;
  logic [3:0] evt, clr_bits;
  logic [31:0] rd_mux;

  // address phase qualification and write strobes
  assign acc = hsel && htrans[1] && hready;
  assign wr1 = wr_pend_r && addr_r == `IRQPLC_IDX_SEL1;
  assign wr2 = wr_pend_r && addr_r == `IRQPLC_IDX_SEL2;
  assign wr3 = wr_pend_r && addr_r == `IRQPLC_IDX_SEL3;
  assign wr_clr = wr_pend_r && addr_r == `IRQPLC_IDX_CLR;
  assign wr_en = wr_pend_r && addr_r == `IRQPLC_IDX_EN;

  // read mux; unmapped words read zero
  assign rd_mux =
    addr_r == `IRQPLC_IDX_SEL1 ? {16'h0000, sel1_r} :
    addr_r == `IRQPLC_IDX_SEL2 ? {16'h0000, sel2_r} :
    addr_r == `IRQPLC_IDX_SEL3 ? {16'h0000, sel3_r} :
    addr_r == `IRQPLC_IDX_STAT ? {28'h0000000, stat_r} :
    addr_r == `IRQPLC_IDX_EN ? {28'h0000000, en_r} :
    addr_r == `IRQPLC_IDX_PEND ?
      {21'h0, core_irq_r, core_lvl_r, core_src_r, 1'b0, lvl_pend_r} :
    32'h00000000;

  // per-source fields, numbered in register order
  assign fld[0] = sel1_r[`IRQPLC_POS_PORT_B +: 2]; // see RULE5
  assign fld[1] = sel1_r[`IRQPLC_POS_PORT_C +: 2]; // see RULE5
  assign fld[2] = sel1_r[`IRQPLC_POS_PORT_D +: 2]; // see RULE5
  assign fld[3] = sel1_r[`IRQPLC_POS_FL_BUF +: 2]; // see RULE6
  assign fld[4] = sel1_r[`IRQPLC_POS_FL_DONE +: 2]; // see RULE6
  assign fld[5] = sel1_r[`IRQPLC_POS_FL_FAULT +: 2]; // see RULE7
  assign fld[6] = sel1_r[`IRQPLC_POS_CLK_LOCK +: 2]; // see RULE7
  assign fld[7] = sel2_r[`IRQPLC_POS_SER_RXF +: 2]; // see RULE8
  assign fld[8] = sel2_r[`IRQPLC_POS_SER_RXE +: 2]; // see RULE8
  assign fld[9] = sel2_r[`IRQPLC_POS_SER_TXI +: 2]; // see RULE9
  assign fld[10] = sel2_r[`IRQPLC_POS_SER_TXE +: 2]; // see RULE9
  assign fld[11] = sel2_r[`IRQPLC_POS_SYN_TX +: 2]; // see RULE10
  assign fld[12] = sel2_r[`IRQPLC_POS_SYN_RX +: 2]; // see RULE10
  assign fld[13] = sel2_r[`IRQPLC_POS_PORT_A +: 2]; // see RULE10
  assign fld[14] = sel3_r[`IRQPLC_POS_CONV_A +: 2]; // see RULE11
  assign fld[15] = sel3_r[`IRQPLC_POS_TIMER3 +: 2]; // see RULE11

  // level decode: code n selects level n-1, code 00 drops the source
  always_comb begin
    for (int l = 0; l < 3; l++) begin
      for (int i = 0; i < 16; i++) begin
        lvl_vec[l][i] = src_req[i] && fld[i] == 2'(l + 1); // see RULE1
      end
      lvl_any[l] = |lvl_vec[l]; // see RULE14
    end
    for (int i = 0; i < 16; i++) begin
      en_vec[i] = |fld[i];
    end
  end

  // core mask: level l is taken only when l is not below the mask
  always_comb begin
    sel_ok = 1'b0;
    sel_lvl = 2'b00;
    for (int l = 0; l < 3; l++) begin
      if (lvl_any[l] && 2'(l) >= core_mask) begin
        sel_ok = 1'b1;
        sel_lvl = 2'(l); // see RULE2
      end
    end
  end

  // sticky status: new pending per level, wake; set beats clear
  // wake status follows the rise of the registered wake line exactly
  assign wake_nxt = low_power && lp_d_r && |(src_req & arm_r);
  assign evt = {wake_nxt && !wake_r, lvl_any & ~lvl_pend_r};
  assign clr_bits = wr_clr ? hwdata[3:0] : 4'h0;
  assign stat_nxt = (stat_r & ~clr_bits) | evt;

  // bus handshake: writes zero wait, reads one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= BUS_IDLE;
      hreadyout_r <= 1'b1;
      hrdata_r <= 32'h00000000;
      wr_pend_r <= 1'b0;
      addr_r <= 6'h00;
    end else begin
      wr_pend_r <= acc && hwrite;
      if (acc) begin
        addr_r <= haddr[7:2];
      end
      unique case (st_r)
        BUS_IDLE: begin
          if (acc && !hwrite) begin
            st_r <= BUS_RDWAIT;
            hreadyout_r <= 1'b0;
          end
        end
        BUS_RDWAIT: begin
          st_r <= BUS_IDLE;
          hreadyout_r <= 1'b1;
          hrdata_r <= rd_mux;
        end
      endcase
    end
  end

  // level select registers; reserved bits never store
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel1_r <= `IRQPLC_RST_SEL; // see RULE4
      sel2_r <= `IRQPLC_RST_SEL; // see RULE4
      sel3_r <= `IRQPLC_RST_SEL; // see RULE4
    end else begin
      if (wr1) begin
        sel1_r <= hwdata[15:0] & `IRQPLC_MASK1; // see RULE3
      end
      if (wr2) begin
        sel2_r <= hwdata[15:0] & `IRQPLC_MASK2; // see RULE3
      end
      if (wr3) begin
        sel3_r <= hwdata[15:0] & `IRQPLC_MASK3;
      end
    end
  end

  // status, enable and interrupt line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= `IRQPLC_RST_STAT;
      en_r <= `IRQPLC_RST_STAT;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      if (wr_en) begin
        en_r <= hwdata[3:0];
      end
      irq_r <= |(stat_r & en_r);
    end
  end

  // encoder outputs and low power wake arming
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_pend_r <= 3'b000;
      core_irq_r <= 1'b0;
      core_lvl_r <= 2'b00;
      core_src_r <= 4'h0;
      lp_d_r <= 1'b0;
      arm_r <= 16'h0000;
      wake_r <= 1'b0;
    end else begin
      lvl_pend_r <= lvl_any; // see RULE14
      core_irq_r <= sel_ok;
      core_lvl_r <= sel_lvl;
      core_src_r <= first_idx(lvl_vec[sel_lvl]); // see RULE12
      lp_d_r <= low_power;
      if (low_power && !lp_d_r) begin
        arm_r <= en_vec; // see RULE13
      end
      wake_r <= wake_nxt; // see RULE13
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign core_irq = core_irq_r;
  assign core_lvl = core_lvl_r;
  assign core_src = core_src_r;
  assign lvl_pend = lvl_pend_r;
  assign wake = wake_r;
  assign irq = irq_r;

  // checks
  property p_rst;
    @(posedge hclk) !hresetn |=> sel1_r == 16'h0000 && sel2_r == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("field not disabled"); // see RULE4

  property p_dec;
    @(posedge hclk) disable iff (!hresetn)
      src_req[0] && fld[0] == 2'b01 |=> lvl_pend_r[0];
  endproperty
  a_dec: assert property (p_dec) else $error("code 01 not level 0"); // see RULE1

  property p_top;
    @(posedge hclk) disable iff (!hresetn)
      src_req[5] && fld[5] == 2'b11 && core_mask != 2'b11
      |=> core_irq_r && core_lvl_r == 2'b10;
  endproperty
  a_top: assert property (p_top) else $error("code 11 not level 2"); // see RULE2

  property p_rsv;
    @(posedge hclk) disable iff (!hresetn)
      wr1 || wr2 |=> sel1_r[9:8] == 2'b00 && sel2_r[11:10] == 2'b00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits stored"); // see RULE3

  property p_r1a;
    @(posedge hclk) disable iff (!hresetn)
      wr1 |=> fld[0] == $past(hwdata[15:14]) && fld[2] == $past(hwdata[11:10]);
  endproperty
  a_r1a: assert property (p_r1a) else $error("port fields misplaced"); // see RULE5

  property p_r1b;
    @(posedge hclk) disable iff (!hresetn)
      wr1 |=> fld[3] == $past(hwdata[7:6]) && fld[4] == $past(hwdata[5:4]);
  endproperty
  a_r1b: assert property (p_r1b) else $error("flash fields misplaced"); // see RULE6

  property p_r1c;
    @(posedge hclk) disable iff (!hresetn)
      wr1 |=> fld[5] == $past(hwdata[3:2]) && fld[6] == $past(hwdata[1:0]);
  endproperty
  a_r1c: assert property (p_r1c) else $error("fault fields misplaced"); // see RULE7

  property p_r2a;
    @(posedge hclk) disable iff (!hresetn)
      wr2 |=> fld[7] == $past(hwdata[15:14]) && fld[8] == $past(hwdata[13:12]);
  endproperty
  a_r2a: assert property (p_r2a) else $error("rx fields misplaced"); // see RULE8

  property p_r2b;
    @(posedge hclk) disable iff (!hresetn)
      wr2 |=> fld[9] == $past(hwdata[9:8]) && fld[10] == $past(hwdata[7:6]);
  endproperty
  a_r2b: assert property (p_r2b) else $error("tx fields misplaced"); // see RULE9

  property p_r2c;
    @(posedge hclk) disable iff (!hresetn)
      wr2 |=> fld[11] == $past(hwdata[5:4]) && fld[13] == $past(hwdata[1:0]);
  endproperty
  a_r2c: assert property (p_r2c) else $error("sync fields misplaced"); // see RULE10

  property p_r3;
    @(posedge hclk) disable iff (!hresetn)
      wr3 |=> fld[14] == $past(hwdata[15:14]) && fld[15] == $past(hwdata[13:12]);
  endproperty
  a_r3: assert property (p_r3) else $error("reg three misplaced"); // see RULE11

  property p_ord;
    @(posedge hclk) disable iff (!hresetn)
      lvl_vec[1][2] && lvl_vec[1][9] && lvl_vec[1][1:0] == 2'b00 &&
      !lvl_any[2] && core_mask <= 2'b01 |=> core_src_r == 4'h2;
  endproperty
  a_ord: assert property (p_ord) else $error("lowest number lost"); // see RULE12

  property p_wake;
    @(posedge hclk) disable iff (!hresetn)
      low_power && lp_d_r && (src_req & arm_r) == 16'h0000 |=> !wake_r;
  endproperty
  a_wake: assert property (p_wake) else $error("wake from unarmed"); // see RULE13

  property p_off;
    @(posedge hclk) disable iff (!hresetn)
      en_vec == 16'h0000 |=> !core_irq_r && lvl_pend_r == 3'b000;
  endproperty
  a_off: assert property (p_off) else $error("disabled source pends"); // see RULE14

endmodule
`default_nettype wire

// ### testbench/irqplc_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// far side: peripheral sources holding level requests
module irqplc_src_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] pat,
  output logic [15:0] src_req
);
  // a request is a level that moves only just after a clock edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) src_req <= 16'h0000;
    else src_req <= pat;
  end
endmodule
`default_nettype wire

// ### testbench/irqplc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module irqplc_top_tb;
  import irqplc_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic low_power = 1'b0, dph = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rs = 32'h0000D9F7;
  logic [1:0] htrans = 2'h0, core_mask = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] pat = 16'h0000, src_req;
  logic [31:0] hrdata;
  logic hreadyout, hresp, core_irq, wake, irq;
  irqplc_lvl_t core_lvl;
  irqplc_src_t core_src;
  logic [2:0] lvl_pend;
  logic [63:0] expq [$];
  logic [63:0] e;
  int n_errors = 0, n_checks = 0;
  int pos [16] = '{14, 12, 10, 6, 4, 2, 0, 14, 12, 8, 6, 4, 2, 0, 14, 12};

  irqplc_src_model i_src (.hclk(hclk), .hresetn(hresetn), .pat(pat),
    .src_req(src_req));
  irqplc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req),
    .core_mask(core_mask), .low_power(low_power), .core_irq(core_irq),
    .core_lvl(core_lvl), .core_src(core_src), .lvl_pend(lvl_pend),
    .wake(wake), .irq(irq));

  // clock at 5 ns
  initial forever #2.5 hclk = ~hclk;

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // expected pending view word
  function automatic logic [31:0] pv(logic q, logic [1:0] l, logic [3:0] s,
    logic [2:0] p);
    return {21'h0, q, l, s, 1'b0, p};
  endfunction

  // one single transfer, held until hready is sampled high
  task automatic xfer(logic [31:0] a, logic w, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  task automatic wr(logic [31:0] a, logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(logic [31:0] a, logic [31:0] x,
    logic [31:0] m = 32'hFFFFFFFF);
    expq.push_back({x, m});
    xfer(a, 1'b0, 32'h0);
  endtask

  task automatic td(string n);
    $display("test %s done", n);
  endtask

  // watcher: compares read data with the oldest note at data phase end
  always @(posedge hclk) begin
    if (dph && hreadyout === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      chk("hrdata", hrdata & e[31:0], e[63:32] & e[31:0]);
      chk("hresp", {31'h0, hresp}, 32'h0);
    end
    if (hreadyout === 1'b1) dph <= hsel && htrans[1] && !hwrite;
  end

  // watchdog
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end

  // main sequence
  initial begin
    logic [1:0] c, k;
    logic [31:0] a, x, m;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 1; i < 8; i++) if (i != 5) rd(32'(i * 4), 32'h0);
    td("reset");
    wr(32'h4, 32'hFFFFFFFF);
    wr(32'h8, 32'hFFFFFFFF);
    wr(32'hC, 32'hFFFFFFFF);
    rd(32'h4, 32'h0000FCFF);
    rd(32'h8, 32'h0000F3FF);
    rd(32'hC, 32'h0000F000);
    wr(32'h40, 32'hFFFFFFFF);
    rd(32'h40, 32'h0);
    rd(32'h0, 32'h0);
    for (int i = 1; i < 4; i++) wr(32'(i * 4), 32'h0);
    td("layout");
    a = xs();
    k = a[1:0];
    for (int s = 0; s < 16; s++) begin
      c = 2'(s) ^ k;
      a = (s < 7) ? 32'h4 : (s < 14) ? 32'h8 : 32'hC;
      wr(a, 32'(c) << pos[s]); // field set before its source asks
      pat <= 16'h1 << s;
      repeat (3) @(posedge hclk);
      m = (c == 2'h0) ? 32'h00000407 : 32'hFFFFFFFF;
      x = (c == 2'h0) ? 32'h0 :
        pv(1'b1, c - 2'h1, 4'(s), 3'h1 << (c - 2'h1));
      chk("pins", {21'h0, core_irq, core_lvl, core_src, 1'b0, lvl_pend} & m,
        x);
      if (c == 2'h0) rd(32'h1C, 32'h0, 32'h407);
      else rd(32'h1C, pv(1'b1, c - 2'h1, 4'(s), 3'h1 << (c - 2'h1)));
      wr(a, 32'h0);
      pat <= 16'h0000;
    end
    td("sources");
    wr(32'h4, 32'h2000);
    wr(32'h8, 32'h8000);
    pat <= 16'h0082;
    repeat (3) @(posedge hclk);
    rd(32'h1C, pv(1'b1, 2'h1, 4'h1, 3'h2));
    core_mask <= 2'h2;
    repeat (2) @(posedge hclk);
    rd(32'h1C, 32'h2, 32'h407);
    core_mask <= 2'h0;
    pat <= 16'h0000;
    // source 0 at level 0, sources 2 and 9 at level 1, source 5 at level 2
    wr(32'h4, 32'h680C);
    wr(32'h8, 32'h8200);
    pat <= 16'h0205;
    repeat (3) @(posedge hclk);
    chk("pins", {21'h0, core_irq, core_lvl, core_src, 1'b0, lvl_pend},
      pv(1'b1, 2'h1, 4'h2, 3'h3));
    rd(32'h1C, pv(1'b1, 2'h1, 4'h2, 3'h3));
    pat <= 16'h0021;
    repeat (3) @(posedge hclk);
    rd(32'h1C, pv(1'b1, 2'h2, 4'h5, 3'h5));
    pat <= 16'h0000;
    td("priority");
    wr(32'h14, 32'hF);
    wr(32'h18, 32'h2);
    rd(32'h18, 32'h2);
    rd(32'h10, 32'h0);
    pat <= 16'h0002;
    repeat (3) @(posedge hclk);
    rd(32'h10, 32'h2);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(32'h18, 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(32'h18, 32'h2);
    wr(32'h14, 32'h2);
    repeat (2) @(posedge hclk);
    chk("irq", {31'h0, irq}, 32'h0);
    rd(32'h10, 32'h0);
    pat <= 16'h0000;
    td("interrupt");
    low_power <= 1'b1;
    repeat (3) @(posedge hclk);
    pat <= 16'h0002;
    repeat (3) @(posedge hclk);
    chk("wake", {31'h0, wake}, 32'h1);
    pat <= 16'h0000;
    low_power <= 1'b0;
    wr(32'h4, 32'h0);
    low_power <= 1'b1;
    repeat (3) @(posedge hclk);
    wr(32'h4, 32'h2000);
    pat <= 16'h0002;
    repeat (3) @(posedge hclk);
    chk("wake", {31'h0, wake}, 32'h0);
    low_power <= 1'b0;
    pat <= 16'h0000;
    td("wake");
    end_of_test();
  end
endmodule
`default_nettype wire
